// ---- sata_scr_pkg.sv ----
// Constants, field layouts and carrier types for the indexed link register set
package sata_scr_pkg;
	localparam int NPORTS = 2;
	// I/O offsets, byte addresses within each window
	localparam logic [3:0] OFF_INDEX = 4'h0;
	localparam logic [3:0] OFF_WINDOW = 4'h4;
	localparam logic [3:0] OFF_RSVD_FIRST = 4'h8;
	localparam logic [3:0] OFF_DESC_PTR = 4'h4;
	localparam logic [7:0] SUBCLASS_IDE = 8'h01;
	// Index register fields and codes
	localparam int PSEL_LSB = 8;
	localparam int RSEL_LSB = 0;
	localparam logic [7:0] PSEL_PORT0 = 8'h00;
	localparam logic [7:0] PSEL_PORT1 = 8'h02;
	localparam logic [7:0] RSEL_STATUS = 8'h00;
	localparam logic [7:0] RSEL_CONTROL = 8'h01;
	localparam logic [7:0] RSEL_FAULT = 8'h02;
	localparam logic [31:0] INDEX_RW_MASK = 32'h0000ffff;
	// Reset values
	localparam logic [31:0] INDEX_RESET = 32'h00000000;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	localparam logic [31:0] CTRL_RESET = 32'h00000004;
	localparam logic [31:0] FAULT_RESET = 32'h00000000;
	localparam logic [31:0] DESC_PTR_RESET = 32'h00000000;
	localparam logic [31:0] DESC_PTR_MASK = 32'hfffffffc;
	// Status fields
	localparam int STS_DET_LSB = 0;
	localparam int STS_SPD_LSB = 4;
	localparam int STS_IPM_LSB = 8;
	localparam logic [3:0] DET_NONE = 4'h0;
	localparam logic [3:0] DET_PRESENT = 4'h1;
	localparam logic [3:0] DET_ONLINE = 4'h3;
	localparam logic [3:0] DET_OFFLINE = 4'h4;
	// Control fields
	localparam int CTL_INIT_LSB = 0;
	localparam int CTL_SPEED_LSB = 4;
	localparam int CTL_PM_LSB = 8;
	localparam int PM_PARTIAL_BIT = 0;
	localparam int PM_SLUMBER_BIT = 1;
	localparam logic [31:0] CTL_RW_MASK = 32'h00000fff;
	localparam logic [3:0] INIT_NONE = 4'h0;
	localparam logic [3:0] INIT_COMRESET = 4'h1;
	localparam logic [3:0] INIT_OFFLINE = 4'h4;
	// Fault register bit positions
	localparam int FLT_RECOV_DATA = 0;
	localparam int FLT_RECOV_COMM = 1;
	localparam int FLT_TRANSIENT = 8;
	localparam int FLT_PERSIST = 9;
	localparam int FLT_PROTOCOL = 10;
	localparam int FLT_INTERNAL = 11;
	localparam int FLT_PHY_READY_SIGNAL_CHG = 16;
	localparam int FLT_PHY_INT = 17;
	localparam int FLT_WAKE = 18;
	localparam int FLT_DECODE = 19;
	localparam int FLT_CRC = 21;
	localparam int FLT_HANDSHAKE = 22;
	localparam int FLT_LINK_SEQ = 23;
	localparam int FLT_TRANSPORT = 24;
	localparam int FLT_UNK_FRAME = 25;
	localparam int FLT_COMINIT = 26;
	localparam logic [31:0] FLT_STOP_MASK = 32'h00000f00;

	typedef struct packed {
		logic pair_cs;
		logic bm_cs;
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} io_req_s;

	typedef struct packed {
		logic present;
		logic phy_ready_signal;
		logic [3:0] power_state_field;
		logic [3:0] link_rate_field;
		logic cominit;
		logic unk_frame;
		logic transport;
		logic link_seq;
		logic handshake;
		logic crc;
		logic decode;
		logic wake;
		logic phy_int;
	} link_in_s;

	typedef struct packed {
		logic internal;
		logic protocol;
		logic persist;
		logic transient;
		logic recov_comm;
		logic recov_data;
	} sys_err_s;

	typedef struct packed {
		logic link_reset;
		logic phy_offline;
		logic [3:0] speed_cap;
		logic partial_block;
		logic slumber_block;
		logic stop_xfer;
		logic port_change_irq_status;
		logic phy_ready_change_irq_status;
	} port_out_s;
endpackage

// ---- sync_2ff.sv ----
// Two-flop synchroniser for a vector of link-side levels
module sync_2ff #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule // sync_2ff

// ---- fault_flags.sv ----
// Write-one-to-clear fault flags of one port, set wins over clear
module fault_flags (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [31:0] set,
	input wire logic [31:0] clr,
	output logic [31:0] flags
);
	import sata_scr_pkg::*;
	logic [31:0] next_flags;

	always_comb begin
		next_flags = (flags & ~clr) | set;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flags <= FAULT_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	property p_w1c;
		@(posedge mclk) disable iff (!rst_n)
		(|clr) |=> ((flags & $past(clr) & ~$past(set)) == 32'h0);
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag survived a clear");

	property p_set_wins;
		@(posedge mclk) disable iff (!rst_n)
		(|set) |=> ((flags & $past(set)) == $past(set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");
endmodule // fault_flags

// ---- sata_port_scr_index_access.sv ----
// Indexed link status, control and fault registers with descriptor pointer
// Notes on behaviour
// - Status follows live link state and reads zero while link reset is driven.
// - Power state field: 0 none, 1 active, 2 partial, 6 slumber.
// - Rate field: 0 no link, 1 first generation, 2 second generation.
// - Presence field: 0 none, 1 device no link, 3 linked, 4 offline.
// - Control bits 11:0 read back last write, bits 31:12 read zero; resets to 00000004h.
// - Control bits 9:8 block partial and/or slumber entry; bits 11:10 block nothing.
// - Control bits 7:4 cap negotiated rate.
// - Init code 1 drives link reset and keeps reading 1 until rewritten.
// - Init code 4 takes the phy offline; code 0 requests nothing.
// - Fault flags clear by writing one; zero leaves them alone.
// - Any phy-ready edge sets its flag, mirrored as interrupt status.
// - Diagnostic flags latch the listed link events, COMINIT mirrored too.
// - Any fault bit 11:8 set stops the current transfer.
// - Error bits 11,10,9,8,1,0 flag the listed system and link errors.
// - Index pair visible only with subclass 01h and not combined mode.
// - Offsets 08h to 0Fh read zero and ignore writes.
// - Port select 00h is port 0, 02h is port 1.
// - Register select 00h status, 01h control, 02h faults.
// - Data window accesses the selected register; it stores nothing.
module sata_port_scr_index_access (
	input wire logic mclk,
	input wire logic rst_n,
	input sata_scr_pkg::io_req_s io,
	input wire logic [7:0] subclass_code,
	input wire logic combined_mode,
	input wire logic [sata_scr_pkg::NPORTS-1:0] port_run_bit,
	input sata_scr_pkg::link_in_s link_in [sata_scr_pkg::NPORTS],
	input sata_scr_pkg::sys_err_s sys_err [sata_scr_pkg::NPORTS],
	output logic [31:0] io_rdata,
	output logic io_rvalid,
	output logic [31:0] descriptor_pointer,
	output sata_scr_pkg::port_out_s port_out [sata_scr_pkg::NPORTS]
);
	import sata_scr_pkg::*;

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		merge = (old & ~lane_mask(be)) | (nw & lane_mask(be));
	endfunction

	logic visible;
	logic pair_wr;
	logic pair_rd;
	logic at_index;
	logic at_window;
	logic at_rsvd;
	logic sel_ok;
	logic win_wr;
	logic [7:0] port_select;
	logic [7:0] register_select;
	logic [NPORTS-1:0] hit_port;
	logic [31:0] index_q;
	logic [31:0] next_index;
	logic [31:0] desc_q;
	logic [31:0] next_desc;
	logic [31:0] rdata_q;
	logic [31:0] next_rdata;
	logic rvalid_q;
	logic next_rvalid;
	logic [31:0] status_q [NPORTS];
	logic [31:0] control_q [NPORTS];
	logic [31:0] faults_q [NPORTS];
	port_out_s out_q [NPORTS];

	// Decode of the index pair window
	always_comb begin
		visible = (subclass_code == SUBCLASS_IDE) && !combined_mode;
		pair_wr = io.pair_cs && io.wr && visible;
		pair_rd = io.pair_cs && io.rd && visible;
		at_rsvd = (io.addr >= OFF_RSVD_FIRST);
		at_index = !at_rsvd && (io.addr[3:2] == OFF_INDEX[3:2]);
		at_window = !at_rsvd && (io.addr[3:2] == OFF_WINDOW[3:2]);
		port_select = index_q[PSEL_LSB +: 8];
		register_select = index_q[RSEL_LSB +: 8];
		hit_port = '0;
		hit_port[0] = (port_select == PSEL_PORT0);
		hit_port[1] = (port_select == PSEL_PORT1);
		sel_ok = (|hit_port) && (register_select <= RSEL_FAULT);
		win_wr = pair_wr && at_window && sel_ok;
	end

	// Index, descriptor pointer and read path
	always_comb begin
		next_index = index_q;
		next_desc = desc_q;
		next_rdata = rdata_q;
		next_rvalid = io.rd && (io.pair_cs || io.bm_cs);
		if (pair_wr && at_index) begin
			next_index = merge(index_q, io.wdata, io.be) & INDEX_RW_MASK;
		end
		if (io.bm_cs && io.wr && (io.addr[3:2] == OFF_DESC_PTR[3:2])) begin
			next_desc = merge(desc_q, io.wdata, io.be) & DESC_PTR_MASK;
		end
		if (io.rd) begin
			next_rdata = 32'h0;
			if (pair_rd && at_index) begin
				next_rdata = index_q;
			end else if (pair_rd && at_window && sel_ok) begin
				case (register_select)
					RSEL_STATUS: next_rdata = status_q[hit_port[1]];
					RSEL_CONTROL: next_rdata = control_q[hit_port[1]];
					RSEL_FAULT: next_rdata = faults_q[hit_port[1]];
					default: next_rdata = 32'h0;
				endcase
			end else if (io.bm_cs && (io.addr[3:2] == OFF_DESC_PTR[3:2])) begin
				next_rdata = desc_q;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			index_q <= INDEX_RESET;
			desc_q <= DESC_PTR_RESET;
			rdata_q <= 32'h0;
			rvalid_q <= 1'b0;
		end else begin
			index_q <= next_index;
			desc_q <= next_desc;
			rdata_q <= next_rdata;
			rvalid_q <= next_rvalid;
		end
	end

	assign io_rdata = rdata_q;
	assign io_rvalid = rvalid_q;
	assign descriptor_pointer = desc_q;

	genvar p;
	generate
		for (p = 0; p < NPORTS; p++) begin : g_port
			link_in_s lsync;
			link_in_s prev_q;
			logic [31:0] next_status;
			logic [31:0] next_control;
			port_out_s next_out;
			logic [31:0] fset;
			logic [31:0] fclr;
			logic [3:0] det;
			logic [3:0] init;

			sync_2ff #(.W($bits(link_in_s))) u_sync (
				.mclk(mclk),
				.rst_n(rst_n),
				.d(link_in[p]),
				.q(lsync)
			);

			fault_flags u_faults (
				.mclk(mclk),
				.rst_n(rst_n),
				.set(fset),
				.clr(fclr),
				.flags(faults_q[p])
			);

			always_comb begin
				det = DET_NONE;
				init = control_q[p][CTL_INIT_LSB +: 4];
				if (lsync.present) begin
					det = lsync.phy_ready_signal ? DET_ONLINE : DET_PRESENT;
				end
				next_status = STATUS_RESET;
				case (init)
					INIT_COMRESET: next_status = STATUS_RESET;
					INIT_OFFLINE: next_status[STS_DET_LSB +: 4] = DET_OFFLINE;
					default: begin
						next_status[STS_DET_LSB +: 4] = det;
						if (det == DET_ONLINE) begin
							// Multi-bit codes can skew through the per-bit synchroniser; take them once steady
							next_status[STS_IPM_LSB +: 4] = status_q[p][STS_IPM_LSB +: 4];
							next_status[STS_SPD_LSB +: 4] = status_q[p][STS_SPD_LSB +: 4];
							if ((lsync.power_state_field == prev_q.power_state_field) &&
								(lsync.link_rate_field == prev_q.link_rate_field)) begin
								next_status[STS_IPM_LSB +: 4] = lsync.power_state_field;
								next_status[STS_SPD_LSB +: 4] = lsync.link_rate_field;
							end
						end
					end
				endcase
				next_control = control_q[p];
				if (win_wr && hit_port[p] && (register_select == RSEL_CONTROL)) begin
					next_control = merge(control_q[p], io.wdata, io.be) & CTL_RW_MASK;
				end
				next_out.link_reset = (init == INIT_COMRESET);
				next_out.phy_offline = (init == INIT_OFFLINE);
				next_out.speed_cap = control_q[p][CTL_SPEED_LSB +: 4];
				next_out.partial_block = control_q[p][CTL_PM_LSB + PM_PARTIAL_BIT];
				next_out.slumber_block = control_q[p][CTL_PM_LSB + PM_SLUMBER_BIT];
				next_out.stop_xfer = |(faults_q[p] & FLT_STOP_MASK);
				next_out.port_change_irq_status = faults_q[p][FLT_COMINIT];
				next_out.phy_ready_change_irq_status = faults_q[p][FLT_PHY_READY_SIGNAL_CHG];
				fset = 32'h0;
				fset[FLT_PHY_READY_SIGNAL_CHG] = lsync.phy_ready_signal ^ prev_q.phy_ready_signal;
				fset[FLT_COMINIT] = lsync.cominit & ~prev_q.cominit;
				fset[FLT_UNK_FRAME] = lsync.unk_frame & ~prev_q.unk_frame;
				fset[FLT_TRANSPORT] = lsync.transport & ~prev_q.transport;
				fset[FLT_LINK_SEQ] = lsync.link_seq & ~prev_q.link_seq;
				fset[FLT_HANDSHAKE] = lsync.handshake & ~prev_q.handshake;
				fset[FLT_CRC] = lsync.crc & ~prev_q.crc;
				fset[FLT_DECODE] = lsync.decode & ~prev_q.decode;
				fset[FLT_WAKE] = lsync.wake & ~prev_q.wake;
				fset[FLT_PHY_INT] = lsync.phy_int & ~prev_q.phy_int;
				fset[FLT_INTERNAL] = sys_err[p].internal;
				fset[FLT_PROTOCOL] = sys_err[p].protocol;
				fset[FLT_PERSIST] = sys_err[p].persist;
				fset[FLT_TRANSIENT] = sys_err[p].transient;
				fset[FLT_RECOV_COMM] = sys_err[p].recov_comm;
				fset[FLT_RECOV_DATA] = sys_err[p].recov_data;
				fclr = 32'h0;
				if (win_wr && hit_port[p] && (register_select == RSEL_FAULT)) begin
					fclr = io.wdata & lane_mask(io.be);
				end
			end

			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					status_q[p] <= STATUS_RESET;
					control_q[p] <= CTRL_RESET;
					out_q[p] <= '0;
					prev_q <= '0;
				end else begin
					status_q[p] <= next_status;
					control_q[p] <= next_control;
					out_q[p] <= next_out;
					prev_q <= lsync;
				end
			end

			assign port_out[p] = out_q[p];

			property p_comreset_zero;
				@(posedge mclk) disable iff (!rst_n)
				(control_q[p][CTL_INIT_LSB +: 4] == INIT_COMRESET) |=>
					(status_q[p] == 32'h0) && out_q[p].link_reset;
			endproperty
			a_comreset_zero: assert property (p_comreset_zero) else $error("reset status");

			property p_offline;
				@(posedge mclk) disable iff (!rst_n)
				(control_q[p][CTL_INIT_LSB +: 4] == INIT_OFFLINE) |=>
					(status_q[p] == {28'h0, DET_OFFLINE}) && out_q[p].phy_offline;
			endproperty
			a_offline: assert property (p_offline) else $error("offline missing");

			property p_ctrl_reset;
				@(posedge mclk) disable iff (!rst_n)
				$rose(rst_n) |-> (control_q[p] == CTRL_RESET);
			endproperty
			a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset");

			property p_phy_ready_signal_edge;
				@(posedge mclk) disable iff (!rst_n)
				(lsync.phy_ready_signal != prev_q.phy_ready_signal) |=>
					faults_q[p][FLT_PHY_READY_SIGNAL_CHG] ##1 out_q[p].phy_ready_change_irq_status;
			endproperty
			a_phy_ready_signal_edge: assert property (p_phy_ready_signal_edge) else $error("phy edge lost");

			property p_stop;
				@(posedge mclk) disable iff (!rst_n)
				(|(faults_q[p] & FLT_STOP_MASK)) |=> out_q[p].stop_xfer;
			endproperty
			a_stop: assert property (p_stop) else $error("transfer not stopped");

			property p_speed_cap;
				@(posedge mclk) disable iff (!rst_n)
				1'b1 |=> (out_q[p].speed_cap == $past(control_q[p][CTL_SPEED_LSB +: 4]));
			endproperty
			a_speed_cap: assert property (p_speed_cap) else $error("speed cap");
		end
	endgenerate

	property p_rsvd_zero;
		@(posedge mclk) disable iff (!rst_n)
		(io.rd && io.pair_cs && (io.addr >= OFF_RSVD_FIRST)) |=> io_rvalid && (io_rdata == 32'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read");

	property p_hidden;
		@(posedge mclk) disable iff (!rst_n)
		(io.rd && io.pair_cs && !io.bm_cs && !visible) |=> (io_rdata == 32'h0);
	endproperty
	a_hidden: assert property (p_hidden) else $error("hidden pair read");

	property p_bad_index;
		@(posedge mclk) disable iff (!rst_n)
		(io.rd && io.pair_cs && !io.bm_cs && at_window && !sel_ok) |=> (io_rdata == 32'h0);
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("reserved index");

	property p_ctrl_window;
		@(posedge mclk) disable iff (!rst_n)
		(win_wr && hit_port[0] && (register_select == RSEL_CONTROL) && (io.be == 4'hf)) |=>
			(control_q[0] == ($past(io.wdata) & CTL_RW_MASK));
	endproperty
	a_ctrl_window: assert property (p_ctrl_window) else $error("window write");
endmodule // sata_port_scr_index_access

// ---- sata_dev_model.sv ----
// Storage device stand-in driving the link-side levels of each port
module sata_dev_model (
	input wire logic [sata_scr_pkg::NPORTS-1:0] attach,
	input wire logic [sata_scr_pkg::NPORTS-1:0] link_up,
	input wire logic [7:0] state [sata_scr_pkg::NPORTS],
	input wire logic [8:0] events [sata_scr_pkg::NPORTS],
	input sata_scr_pkg::port_out_s port_out [sata_scr_pkg::NPORTS],
	output sata_scr_pkg::link_in_s link_in [sata_scr_pkg::NPORTS]
);
	timeunit 1ns;
	timeprecision 1ps;
	import sata_scr_pkg::*;
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			link_in[p].present = attach[p];
			// Link drops while the host holds reset or offline
			link_in[p].phy_ready_signal = attach[p] & link_up[p] & ~port_out[p].link_reset
				& ~port_out[p].phy_offline;
			// Power and rate stay driven even unlinked, host must mask them
			link_in[p].power_state_field = state[p][7:4];
			link_in[p].link_rate_field = state[p][3:0];
			{link_in[p].cominit, link_in[p].unk_frame, link_in[p].transport, link_in[p].link_seq,
				link_in[p].handshake, link_in[p].crc, link_in[p].decode, link_in[p].wake,
				link_in[p].phy_int} = events[p];
		end
	end
endmodule // sata_dev_model

// ---- sata_port_scr_index_access_tb_top.sv ----
// Self-checking bench for the indexed link register set
module sata_port_scr_index_access_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sata_scr_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	io_req_s io = '0;
	logic [7:0] subclass_code = 8'h01;
	logic combined_mode = 1'b0;
	logic [NPORTS-1:0] port_run_bit = '0;
	logic [NPORTS-1:0] attach = '0;
	logic [NPORTS-1:0] link_up = '0;
	logic [7:0] state [NPORTS] = '{8'h62, 8'h00};
	logic [8:0] events [NPORTS] = '{9'h0, 9'h0};
	link_in_s link_in [NPORTS];
	sys_err_s sys_err [NPORTS] = '{'0, '0};
	logic [31:0] io_rdata;
	logic io_rvalid;
	logic [31:0] descriptor_pointer;
	port_out_s port_out [NPORTS];
	logic [31:0] rdat;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int fpos [9] = '{FLT_COMINIT, FLT_UNK_FRAME, FLT_TRANSPORT, FLT_LINK_SEQ, FLT_HANDSHAKE,
		FLT_CRC, FLT_DECODE, FLT_WAKE, FLT_PHY_INT};
	int spos [6] = '{11, 10, 9, 8, 1, 0};
	logic [7:0] st [3] = '{8'h11, 8'h22, 8'h61};

	sata_port_scr_index_access sata_port_scr_index_access_i (.mclk(mclk), .rst_n(rst_n), .io(io),
		.subclass_code(subclass_code), .combined_mode(combined_mode),
		.port_run_bit(port_run_bit), .link_in(link_in), .sys_err(sys_err), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .descriptor_pointer(descriptor_pointer), .port_out(port_out));
	sata_dev_model sata_dev_model_i (.attach(attach), .link_up(link_up), .state(state),
		.events(events), .port_out(port_out), .link_in(link_in));

	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One access; a read is answered exactly one cycle after its edge
	task automatic acc(input logic bm, input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		@(posedge mclk);
		io <= '{pair_cs: ~bm, bm_cs: bm, wr: w, rd: ~w, addr: a, be: be, wdata: d};
		@(posedge mclk);
		io <= '0;
		if (!w) begin
			@(negedge mclk);
			chk(32'(io_rvalid), 32'h1);
			rdat = io_rdata;
			// Return on a rising edge so callers drive at the edge
			@(posedge mclk);
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] want);
		acc(1'b0, 1'b0, a, 32'h0);
		chk(rdat, want);
	endtask
	task automatic wreg(input logic [7:0] ps, input logic [7:0] rs, input logic [31:0] d);
		acc(1'b0, 1'b1, OFF_INDEX, {16'h0, ps, rs});
		acc(1'b0, 1'b1, OFF_WINDOW, d);
	endtask
	task automatic rreg(input logic [7:0] ps, input logic [7:0] rs, input logic [31:0] want);
		acc(1'b0, 1'b1, OFF_INDEX, {16'h0, ps, rs});
		rdc(OFF_WINDOW, want);
	endtask

	initial begin
		wt(10);
		rst_n <= 1'b1;
		wt(6);
		rdc(OFF_INDEX, 32'h0);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h4);
		rreg(PSEL_PORT1, RSEL_CONTROL, 32'h4);
		rreg(PSEL_PORT0, RSEL_FAULT, 32'h0);
		chk(32'(port_out[0].phy_offline), 32'h1);
		$display("test reset done");
		acc(1'b1, 1'b1, OFF_DESC_PTR, 32'hffffffff);
		acc(1'b1, 1'b0, OFF_DESC_PTR, 32'h0);
		chk(rdat, 32'hfffffffc);
		chk(descriptor_pointer, 32'hfffffffc);
		acc(1'b1, 1'b0, 4'h0, 32'h0);
		chk(rdat, 32'h0);
		$display("test pointer done");
		for (int v = 0; v < 4; v++) begin
			wreg(PSEL_PORT1, RSEL_CONTROL, {20'h0, 4'(v), 4'(v % 3), 4'h0});
			rreg(PSEL_PORT1, RSEL_CONTROL, {20'h0, 4'(v), 4'(v % 3), 4'h0});
			chk({30'h0, port_out[1].slumber_block, port_out[1].partial_block}, 32'(v));
			chk(32'(port_out[1].speed_cap), 32'(v % 3));
		end
		acc(1'b0, 1'b1, OFF_WINDOW, 32'h00000100, 4'h2);
		rreg(PSEL_PORT1, RSEL_CONTROL, 32'h100);
		$display("test control done");
		attach[0] <= 1'b1;
		wreg(PSEL_PORT0, RSEL_CONTROL, {28'h0, INIT_NONE});
		wt(6);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h1);
		link_up[0] <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			state[0] <= st[k];
			wt(6);
			rreg(PSEL_PORT0, RSEL_STATUS, {20'h0, st[k], 4'h3});
		end
		wreg(PSEL_PORT0, RSEL_CONTROL, {28'h0, INIT_OFFLINE});
		wt(6);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h4);
		wreg(PSEL_PORT0, RSEL_CONTROL, {28'h0, INIT_COMRESET});
		wt(6);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h0);
		rreg(PSEL_PORT0, RSEL_CONTROL, 32'h1);
		chk(32'(port_out[0].link_reset), 32'h1);
		wreg(PSEL_PORT0, RSEL_CONTROL, {28'h0, INIT_NONE});
		wt(6);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h613);
		$display("test status done");
		wreg(PSEL_PORT0, RSEL_FAULT, 32'hffffffff);
		rreg(PSEL_PORT0, RSEL_FAULT, 32'h0);
		for (int i = 0; i < 9; i++) begin
			events[0] <= 9'h100 >> i;
			wt(3);
			events[0] <= 9'h0;
			wt(5);
			if (i == 0) chk(32'(port_out[0].port_change_irq_status), 32'h1);
			wreg(PSEL_PORT0, RSEL_FAULT, ~(32'h1 << fpos[i]));
			rreg(PSEL_PORT0, RSEL_FAULT, 32'h1 << fpos[i]);
			wreg(PSEL_PORT0, RSEL_FAULT, 32'h1 << fpos[i]);
			rreg(PSEL_PORT0, RSEL_FAULT, 32'h0);
		end
		for (int e = 0; e < 2; e++) begin
			link_up[0] <= e[0];
			wt(6);
			chk(32'(port_out[0].phy_ready_change_irq_status), 32'h1);
			rreg(PSEL_PORT0, RSEL_FAULT, 32'h1 << FLT_PHY_READY_SIGNAL_CHG);
			wreg(PSEL_PORT0, RSEL_FAULT, 32'hffffffff);
		end
		for (int j = 0; j < 6; j++) begin
			sys_err[1] <= sys_err_s'(6'h20 >> j);
			wt(1);
			sys_err[1] <= '0;
			rreg(PSEL_PORT1, RSEL_FAULT, 32'h1 << spos[j]);
			chk(32'(port_out[1].stop_xfer), 32'(j < 4));
			wreg(PSEL_PORT1, RSEL_FAULT, 32'hffffffff);
		end
		$display("test faults done");
		acc(1'b0, 1'b1, 4'h8, 32'hffffffff);
		rdc(4'h8, 32'h0);
		rdc(4'hc, 32'h0);
		wreg(8'h01, RSEL_CONTROL, 32'h0);
		rreg(8'h01, RSEL_CONTROL, 32'h0);
		rreg(PSEL_PORT0, 8'h03, 32'h0);
		rreg(PSEL_PORT1, RSEL_CONTROL, 32'h100);
		wreg(PSEL_PORT0, RSEL_STATUS, 32'hffffffff);
		rreg(PSEL_PORT0, RSEL_STATUS, 32'h613);
		acc(1'b0, 1'b1, OFF_INDEX, 32'h201);
		subclass_code <= 8'h00;
		rdc(OFF_INDEX, 32'h0);
		acc(1'b0, 1'b1, OFF_INDEX, 32'h0);
		subclass_code <= 8'h01;
		combined_mode <= 1'b1;
		rdc(OFF_INDEX, 32'h0);
		combined_mode <= 1'b0;
		rdc(OFF_INDEX, 32'h201);
		$display("test window done");
		end_of_test();
	end
endmodule // sata_port_scr_index_access_tb_top
